// file: panel_seq_pkg.sv
// constants and carrier types for the front-panel channel sequencer
package panel_seq_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 18;
    localparam int ADV_WAIT_MS = 2000;
    localparam int ADV_STEP_MS = 500;
    localparam int DEBOUNCE_MS = 20;
    localparam int BLINK_HALF_MS = 250;
    localparam int MS_NS = 1000000;
    localparam int ADV_WAIT_TICKS = ADV_WAIT_MS * (MS_NS / TICK_PERIOD_NS);
    localparam int ADV_STEP_TICKS = ADV_STEP_MS * (MS_NS / TICK_PERIOD_NS);
    localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * (MS_NS / TICK_PERIOD_NS);
    localparam int BLINK_TICKS = BLINK_HALF_MS * (MS_NS / TICK_PERIOD_NS);
    localparam int ADV_W = 12;
    localparam int DB_W = 5;
    localparam int BLINK_W = 8;
    localparam int NUM_CHAN = 32;
    localparam int CHAN_W = 5;
    localparam int PCT_W = 7;
    localparam logic [CHAN_W-1:0] SELF_TEST_CHAN = 5'h00;
    localparam logic [CHAN_W-1:0] SENSOR_TEST_CHAN = 5'h17;
    localparam logic [CHAN_W-1:0] FIRST_SCAN_CHAN = 5'h01;
    localparam logic [CHAN_W-1:0] LAST_CHAN_DEFAULT = 5'h1E;
    localparam logic [PCT_W-1:0] SELF_TEST_MIN_PCT = 7'h28;
    localparam logic [PCT_W-1:0] SELF_TEST_MAX_PCT = 7'h3C;
    localparam int NUM_BTN = 5;
    localparam int BTN_RUN = 0;
    localparam int BTN_ADV = 1;
    localparam int BTN_HOLD = 2;
    localparam int BTN_MON = 3;
    localparam int BTN_SENSOR = 4;

    typedef enum logic [1:0] {
        grade_good = 2'h0,
        grade_caution = 2'h1,
        grade_remove = 2'h2
    } grade_t;

    typedef struct packed {
        grade_t grade;
        logic [PCT_W-1:0] pct;
        logic sensor_open;
    } result_t;

    typedef struct packed {
        logic [3:0] tens;
        logic [3:0] ones;
    } digits_t;

    typedef struct packed {
        logic good;
        logic caution;
        logic remove;
        logic sensor_open;
        logic self_test_fail;
    } lamps_t;

    typedef enum logic [5:0] {
        st_self = 6'h01,
        st_idle = 6'h02,
        st_scan = 6'h04,
        st_halt = 6'h08,
        st_hold = 6'h10,
        st_monitor = 6'h20
    } mode_t;
endpackage

// file: panel_channel_sequencer.sv
// pushbutton-driven channel sequencer: scan, halt, advance, monitor, self test
module panel_channel_sequencer #(
    parameter int unsigned TICK_CYC = panel_seq_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic run_button,
    input wire logic advance_button,
    input wire logic hold_button,
    input wire logic monitor_button,
    input wire logic sensor_test_button,
    input wire logic [panel_seq_pkg::CHAN_W-1:0] last_chan,
    input wire logic eoc,
    input wire panel_seq_pkg::result_t result,
    output logic meas_run,
    output logic meas_start,
    output logic [panel_seq_pkg::CHAN_W-1:0] mux_addr,
    output logic [panel_seq_pkg::NUM_CHAN-1:0] shunt_en,
    output logic self_test_source_en,
    output panel_seq_pkg::digits_t chan_digits,
    output logic digits_lit,
    output logic [panel_seq_pkg::PCT_W-1:0] pct_readout,
    output panel_seq_pkg::lamps_t lamps,
    output logic all_done
);
    typedef struct packed {
        logic [panel_seq_pkg::NUM_BTN-1:0] sync1;
        logic [panel_seq_pkg::NUM_BTN-1:0] sync2;
        logic [panel_seq_pkg::NUM_BTN-1:0] stable;
        logic [panel_seq_pkg::NUM_BTN-1:0][panel_seq_pkg::DB_W-1:0] db_cnt;
        logic [panel_seq_pkg::TICK_W-1:0] tick_cnt;
        panel_seq_pkg::mode_t mode;
        logic [panel_seq_pkg::CHAN_W-1:0] chan;
        logic [panel_seq_pkg::CHAN_W-1:0] disp_chan;
        panel_seq_pkg::result_t disp;
        panel_seq_pkg::result_t [panel_seq_pkg::NUM_CHAN-1:0] mem;
        logic meas_on;
        logic start;
        logic st_fail;
        logic done;
        logic [panel_seq_pkg::ADV_W-1:0] adv_cnt;
        logic adv_long;
        logic [panel_seq_pkg::BLINK_W-1:0] blink_cnt;
        logic blink_on;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic tick;
    logic adv_ok;
    logic adv_step;
    logic [panel_seq_pkg::NUM_BTN-1:0] press;
    logic [panel_seq_pkg::CHAN_W-1:0] step_chan;

    // wraps past the configured last channel back to the first scan channel
    function automatic logic [panel_seq_pkg::CHAN_W-1:0] next_chan(
        input logic [panel_seq_pkg::CHAN_W-1:0] c,
        input logic [panel_seq_pkg::CHAN_W-1:0] last
    );
        if (c >= last)
            return panel_seq_pkg::FIRST_SCAN_CHAN;
        return c + 5'h01;
    endfunction

    function automatic panel_seq_pkg::digits_t to_bcd(
        input logic [panel_seq_pkg::CHAN_W-1:0] c
    );
        panel_seq_pkg::digits_t d;
        d.tens = 4'h0;
        d.ones = 4'h0;
        if (c >= 5'h1E)
        begin
            d.tens = 4'h3;
            d.ones = 4'(c - 5'h1E);
        end
        else if (c >= 5'h14)
        begin
            d.tens = 4'h2;
            d.ones = 4'(c - 5'h14);
        end
        else if (c >= 5'h0A)
        begin
            d.tens = 4'h1;
            d.ones = 4'(c - 5'h0A);
        end
        else
            d.ones = 4'(c);
        return d;
    endfunction

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.start = 1'b0;
        press = '0;
        adv_step = 1'b0;
        tick = (s_ff.tick_cnt == panel_seq_pkg::TICK_W'(TICK_CYC - 1));
        nxt_s.tick_cnt = tick ? '0 : s_ff.tick_cnt + 18'h00001;

        // two flops first, then a millisecond-sampled stability count
        nxt_s.sync1 = {sensor_test_button, monitor_button, hold_button,
            advance_button, run_button};
        nxt_s.sync2 = s_ff.sync1;
        for (int i = 0; i < panel_seq_pkg::NUM_BTN; i++)
        begin
            if (s_ff.sync2[i] == s_ff.stable[i])
                nxt_s.db_cnt[i] = '0;
            else if (tick)
            begin
                if (s_ff.db_cnt[i] == panel_seq_pkg::DB_W'(panel_seq_pkg::DEBOUNCE_TICKS - 1))
                begin
                    nxt_s.db_cnt[i] = '0;
                    nxt_s.stable[i] = s_ff.sync2[i];
                    press[i] = s_ff.sync2[i];
                end
                else
                    nxt_s.db_cnt[i] = s_ff.db_cnt[i] + 5'h01;
            end
        end

        // advance never runs while a measurement is in flight
        adv_ok = (s_ff.mode == panel_seq_pkg::st_idle) || (s_ff.mode == panel_seq_pkg::st_halt)
            || (s_ff.mode == panel_seq_pkg::st_hold);
        if (adv_ok && (s_ff.stable[panel_seq_pkg::BTN_ADV] || press[panel_seq_pkg::BTN_ADV]))
        begin
            if (press[panel_seq_pkg::BTN_ADV])
            begin
                adv_step = 1'b1;
                nxt_s.adv_cnt = '0;
                nxt_s.adv_long = 1'b0;
            end
            else if (tick)
            begin
                nxt_s.adv_cnt = s_ff.adv_cnt + 12'h001;
                if (!s_ff.adv_long && s_ff.adv_cnt ==
                    panel_seq_pkg::ADV_W'(panel_seq_pkg::ADV_WAIT_TICKS - 1))
                begin
                    adv_step = 1'b1;
                    nxt_s.adv_long = 1'b1;
                    nxt_s.adv_cnt = '0;
                end
                else if (s_ff.adv_long && s_ff.adv_cnt ==
                    panel_seq_pkg::ADV_W'(panel_seq_pkg::ADV_STEP_TICKS - 1))
                begin
                    adv_step = 1'b1;
                    nxt_s.adv_cnt = '0;
                end
            end
        end
        else
        begin
            nxt_s.adv_cnt = '0;
            nxt_s.adv_long = 1'b0;
        end
        step_chan = next_chan(s_ff.disp_chan, last_chan);
        if (adv_step)
        begin
            // only stored results, also after a completed scan
            nxt_s.chan = step_chan;
            nxt_s.disp_chan = step_chan;
            nxt_s.disp = s_ff.mem[step_chan];
        end

        // a finished cycle is stored and shown in every measuring mode
        if (s_ff.meas_on && eoc)
        begin
            nxt_s.mem[s_ff.chan] = result;
            nxt_s.disp = result;
            nxt_s.disp_chan = s_ff.chan;
        end

        case (s_ff.mode)
            panel_seq_pkg::st_self:
            begin
                if (eoc)
                begin
                    nxt_s.st_fail = !(result.grade == panel_seq_pkg::grade_caution
                        && result.pct >= panel_seq_pkg::SELF_TEST_MIN_PCT
                        && result.pct <= panel_seq_pkg::SELF_TEST_MAX_PCT);
                    nxt_s.meas_on = 1'b0;
                    nxt_s.mode = panel_seq_pkg::st_idle;
                end
            end
            panel_seq_pkg::st_idle:
            begin
                if (press[panel_seq_pkg::BTN_RUN])
                begin
                    nxt_s.chan = panel_seq_pkg::FIRST_SCAN_CHAN;
                    nxt_s.done = 1'b0;
                    nxt_s.meas_on = 1'b1;
                    nxt_s.start = 1'b1;
                    nxt_s.mode = panel_seq_pkg::st_scan;
                end
            end
            panel_seq_pkg::st_scan:
            begin
                if (press[panel_seq_pkg::BTN_HOLD])
                begin
                    nxt_s.meas_on = 1'b0;
                    nxt_s.mode = panel_seq_pkg::st_hold;
                end
                else if (eoc)
                begin
                    if (result.grade != panel_seq_pkg::grade_good)
                    begin
                        nxt_s.meas_on = 1'b0;
                        nxt_s.mode = panel_seq_pkg::st_halt;
                    end
                    else if (s_ff.chan >= last_chan)
                    begin
                        nxt_s.meas_on = 1'b0;
                        nxt_s.done = 1'b1;
                        nxt_s.mode = panel_seq_pkg::st_idle;
                    end
                    else
                    begin
                        nxt_s.chan = next_chan(s_ff.chan, last_chan);
                        nxt_s.start = 1'b1;
                    end
                end
            end
            panel_seq_pkg::st_halt:
            begin
                if (press[panel_seq_pkg::BTN_MON])
                begin
                    nxt_s.meas_on = 1'b1;
                    nxt_s.start = 1'b1;
                    nxt_s.mode = panel_seq_pkg::st_monitor;
                end
                else if (press[panel_seq_pkg::BTN_RUN])
                begin
                    nxt_s.chan = next_chan(s_ff.chan, last_chan);
                    nxt_s.meas_on = 1'b1;
                    nxt_s.start = 1'b1;
                    nxt_s.mode = panel_seq_pkg::st_scan;
                end
            end
            panel_seq_pkg::st_hold:
            begin
                // run remeasures the held channel: it may have been cut short
                if (press[panel_seq_pkg::BTN_MON])
                begin
                    nxt_s.meas_on = 1'b1;
                    nxt_s.start = 1'b1;
                    nxt_s.mode = panel_seq_pkg::st_monitor;
                end
                else if (press[panel_seq_pkg::BTN_RUN])
                begin
                    nxt_s.meas_on = 1'b1;
                    nxt_s.start = 1'b1;
                    nxt_s.mode = panel_seq_pkg::st_scan;
                end
            end
            panel_seq_pkg::st_monitor:
            begin
                if (press[panel_seq_pkg::BTN_HOLD])
                begin
                    nxt_s.meas_on = 1'b0;
                    nxt_s.mode = panel_seq_pkg::st_hold;
                end
                else if (eoc)
                    nxt_s.start = 1'b1;
            end
            default:
            begin
                nxt_s.meas_on = 1'b0;
                nxt_s.mode = panel_seq_pkg::st_idle;
            end
        endcase

        // digits flash at half-second period only while measuring
        if (!s_ff.meas_on)
        begin
            nxt_s.blink_cnt = '0;
            nxt_s.blink_on = 1'b1;
        end
        else if (tick)
        begin
            if (s_ff.blink_cnt == panel_seq_pkg::BLINK_W'(panel_seq_pkg::BLINK_TICKS - 1))
            begin
                nxt_s.blink_cnt = '0;
                nxt_s.blink_on = !s_ff.blink_on;
            end
            else
                nxt_s.blink_cnt = s_ff.blink_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            s_ff <= '0;
            s_ff.mode <= panel_seq_pkg::st_self;
            s_ff.chan <= panel_seq_pkg::SELF_TEST_CHAN;
            s_ff.meas_on <= 1'b1;
            s_ff.start <= 1'b1;
            s_ff.blink_on <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    assign meas_run = s_ff.meas_on;
    assign meas_start = s_ff.start;
    assign mux_addr = s_ff.chan;
    // one shunt released, the rest grounded against crosstalk
    assign shunt_en = ~(32'h00000001 << s_ff.chan);
    assign self_test_source_en = (s_ff.chan == panel_seq_pkg::SELF_TEST_CHAN)
        || s_ff.stable[panel_seq_pkg::BTN_SENSOR];
    assign chan_digits = to_bcd(s_ff.disp_chan);
    assign digits_lit = !s_ff.meas_on || s_ff.blink_on;
    assign pct_readout = s_ff.disp.pct;
    // unknown grade codes fall to remove, so exactly one grade lamp is lit
    assign lamps.good = (s_ff.disp.grade == panel_seq_pkg::grade_good);
    assign lamps.caution = (s_ff.disp.grade == panel_seq_pkg::grade_caution);
    assign lamps.remove = !lamps.good && !lamps.caution;
    assign lamps.sensor_open = s_ff.disp.sensor_open;
    assign lamps.self_test_fail = s_ff.st_fail;
    assign all_done = s_ff.done;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_scan_halt_bad: assert property (
        (s_ff.mode == panel_seq_pkg::st_scan) && eoc && !press[panel_seq_pkg::BTN_HOLD]
        && result.grade != panel_seq_pkg::grade_good
        |=> (s_ff.mode == panel_seq_pkg::st_halt) && !meas_run && !lamps.good)
        else $error("abnormal result did not halt the scan");

    chk_scan_next_chan: assert property (
        (s_ff.mode == panel_seq_pkg::st_scan) && eoc && !press[panel_seq_pkg::BTN_HOLD]
        && result.grade == panel_seq_pkg::grade_good && s_ff.chan < last_chan
        |=> meas_start && meas_run && mux_addr == $past(mux_addr) + 5'h01)
        else $error("good result did not advance the scan");

    chk_eoc_stores: assert property (
        meas_run && eoc |=> s_ff.disp_chan == $past(mux_addr) && pct_readout == $past(result.pct))
        else $error("end of cycle result not shown");

    chk_adv_no_meas: assert property (
        adv_ok && press[panel_seq_pkg::BTN_ADV] && !press[panel_seq_pkg::BTN_RUN]
        && !press[panel_seq_pkg::BTN_MON] |=> !meas_run [*3])
        else $error("advance started a measurement");

    chk_adv_wrap: assert property (
        adv_step && s_ff.disp_chan >= last_chan |=> s_ff.disp_chan == panel_seq_pkg::FIRST_SCAN_CHAN)
        else $error("advance did not wrap to first channel");

    chk_hold_stops: assert property (
        press[panel_seq_pkg::BTN_HOLD]
        && (s_ff.mode == panel_seq_pkg::st_scan || s_ff.mode == panel_seq_pkg::st_monitor)
        |=> (s_ff.mode == panel_seq_pkg::st_hold) && !meas_run)
        else $error("hold did not stop the function");

    chk_monitor_repeat: assert property (
        (s_ff.mode == panel_seq_pkg::st_monitor) && eoc && !press[panel_seq_pkg::BTN_HOLD]
        |=> meas_start && $stable(mux_addr))
        else $error("monitor did not restart on the same channel");

    chk_shunt_single: assert property (
        $onehot(~shunt_en) && !shunt_en[mux_addr])
        else $error("shunt pattern does not isolate one channel");

    chk_lamp_single: assert property (
        $onehot({lamps.good, lamps.caution, lamps.remove}))
        else $error("status lamps not exactly one");

    chk_digits_steady: assert property (
        !meas_run |-> digits_lit)
        else $error("digits dark while idle");

    chk_self_pass: assert property (
        (s_ff.mode == panel_seq_pkg::st_self) && eoc
        && result.grade == panel_seq_pkg::grade_caution
        && result.pct >= panel_seq_pkg::SELF_TEST_MIN_PCT
        && result.pct <= panel_seq_pkg::SELF_TEST_MAX_PCT
        |=> !lamps.self_test_fail && (s_ff.mode == panel_seq_pkg::st_idle))
        else $error("self test in range flagged as failed");

    chk_test_source: assert property (
        (mux_addr != panel_seq_pkg::SELF_TEST_CHAN) && !$past(sensor_test_button, 3)
        && !$past(sensor_test_button, 2) && !s_ff.stable[panel_seq_pkg::BTN_SENSOR]
        |-> !self_test_source_en)
        else $error("test source enabled off channel 0");
endmodule

// file: proc_model.sv
// processor stand-in: answers each measurement start with end of cycle unless meas_run drops first
module proc_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic meas_run,
    input wire logic meas_start,
    input wire logic [panel_seq_pkg::CHAN_W-1:0] mux_addr,
    input wire logic [11:0] lat,
    input wire logic [6:0] self_pct,
    input wire logic [4:0] bad_chan,
    input wire logic [1:0] bad_grade,
    input wire logic [4:0] open_chan,
    output logic eoc,
    output panel_seq_pkg::result_t result
);
    logic [11:0] cnt_ff;
    logic busy_ff;
    logic [4:0] ch_ff;
    panel_seq_pkg::result_t res_v;
    always_comb
    begin
        res_v.grade = panel_seq_pkg::grade_good;
        res_v.pct = {2'h0, ch_ff};
        res_v.sensor_open = (ch_ff == open_chan);
        if (ch_ff == 5'h00)
        begin
            res_v.grade = panel_seq_pkg::grade_caution;
            res_v.pct = self_pct;
        end
        else if (ch_ff == bad_chan)
        begin
            res_v.grade = panel_seq_pkg::grade_t'(bad_grade);
            res_v.pct = 7'h46;
        end
    end
    // result toggles outside eoc so a stale value is never mistaken for valid
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 12'h000;
            ch_ff <= 5'h00;
            eoc <= 1'b0;
            result <= '0;
        end
        else
        begin
            eoc <= 1'b0;
            result <= ~result;
            if (meas_start)
            begin
                busy_ff <= 1'b1;
                cnt_ff <= lat;
                ch_ff <= mux_addr;
            end
            else if (!meas_run)
                busy_ff <= 1'b0;
            else if (busy_ff && cnt_ff == 12'h000)
            begin
                busy_ff <= 1'b0;
                eoc <= 1'b1;
                result <= res_v;
            end
            else if (busy_ff)
                cnt_ff <= cnt_ff - 12'h001;
        end
    end
endmodule

// file: panel_channel_sequencer_tb.sv
// self-checking bench for the front-panel channel sequencer
module panel_channel_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [6:0] st_pct;
        logic [4:0] bad;
        logic [1:0] grade;
        logic [4:0] open;
        logic [4:0] lamps;
    } row_t;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] btn = 5'h00;
    logic [4:0] last_chan = 5'h1E;
    logic [11:0] lat = 12'h028;
    logic [6:0] self_pct = 7'h32;
    logic [4:0] bad_chan = 5'h1F;
    logic [1:0] bad_grade = 2'h1;
    logic [4:0] open_chan = 5'h1F;
    logic eoc, meas_run, meas_start, stse, digits_lit, all_done;
    logic [4:0] mux_addr;
    logic [31:0] shunt_en;
    logic [6:0] pct_readout;
    panel_seq_pkg::result_t result;
    panel_seq_pkg::digits_t chan_digits;
    panel_seq_pkg::lamps_t lamps;
    int fails = 0;
    int tests_run = 0;
    int k;
    int starts = 0;
    int start_mark = 0;
    row_t rows [5] = '{'{7'h32, 5'h03, 2'h1, 5'h1F, 5'h08}, '{7'h27, 5'h0C, 2'h2, 5'h1F, 5'h05},
        '{7'h3D, 5'h11, 2'h3, 5'h1F, 5'h05}, '{7'h28, 5'h05, 2'h1, 5'h05, 5'h0A},
        '{7'h3C, 5'h0A, 2'h2, 5'h1F, 5'h04}};
    always #2.5 clock = ~clock;
    always @(posedge clock)
        if (meas_start === 1'b1)
            starts <= starts + 1;
    panel_channel_sequencer #(.TICK_CYC(4)) u_dut (.clock(clock), .nrst(nrst),
        .run_button(btn[0]), .advance_button(btn[1]), .hold_button(btn[2]),
        .monitor_button(btn[3]), .sensor_test_button(btn[4]), .last_chan(last_chan),
        .eoc(eoc), .result(result), .meas_run(meas_run), .meas_start(meas_start),
        .mux_addr(mux_addr), .shunt_en(shunt_en), .self_test_source_en(stse),
        .chan_digits(chan_digits), .digits_lit(digits_lit), .pct_readout(pct_readout),
        .lamps(lamps), .all_done(all_done));
    proc_model u_proc (.clock(clock), .nrst(nrst), .meas_run(meas_run),
        .meas_start(meas_start), .mux_addr(mux_addr), .lat(lat), .self_pct(self_pct),
        .bad_chan(bad_chan), .bad_grade(bad_grade), .open_chan(open_chan), .eoc(eoc),
        .result(result));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // debounce needs 2 sync flops plus 20 ticks of 4 cycles
    task automatic press(input int b);
        btn[b] = 1'b1;
        cyc(100);
        btn[b] = 1'b0;
        cyc(100);
    endtask
    task automatic wait_stop();
        k = 0;
        while (meas_run !== 1'b0 && k < 20000)
        begin
            cyc(1);
            k++;
        end
    endtask
    function automatic logic [7:0] bcd(input logic [4:0] c);
        return {4'(c / 10), 4'(c % 10)};
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
    initial
    begin
        foreach (rows[i])
        begin
            self_pct = rows[i].st_pct;
            bad_chan = rows[i].bad;
            bad_grade = rows[i].grade;
            open_chan = rows[i].open;
            nrst = 1'b0;
            cyc(10);
            nrst = 1'b1;
            wait_stop();
            press(0);
            wait_stop();
            chk_val("digits", 32'(bcd(rows[i].bad)), 32'(chan_digits));
            chk_val("lamps", 32'(rows[i].lamps), 32'(lamps));
            chk_val("pct", 32'h46, 32'(pct_readout));
            chk_val("shunt", ~(32'h1 << rows[i].bad), shunt_en);
            chk_bit("source", 1'b0, stse);
            $display("row %0d done", i);
        end
        // sixth reset, after the five row resets, lands in mid-scan
        bad_chan = 5'h1F;
        last_chan = 5'h04;
        btn[0] = 1'b1;
        cyc(150);
        btn[0] = 1'b0;
        nrst = 1'b0;
        cyc(10);
        chk_val("rst addr", 32'h0, 32'(mux_addr));
        chk_val("rst lamps", 32'h10, 32'(lamps));
        chk_val("rst digits", 32'h0, 32'(chan_digits));
        chk_bit("rst run", 1'b1, meas_run);
        chk_bit("rst source", 1'b1, stse);
        chk_bit("rst done", 1'b0, all_done);
        nrst = 1'b1;
        wait_stop();
        $display("reset test done");
        start_mark = starts;
        press(0);
        wait_stop();
        chk_bit("all done", 1'b1, all_done);
        chk_val("scan starts", 32'h4, 32'(starts - start_mark));
        chk_val("last digits", 32'h04, 32'(chan_digits));
        press(3);
        chk_bit("monitor in idle", 1'b0, meas_run);
        press(1);
        chk_val("adv digits", 32'h01, 32'(chan_digits));
        chk_val("adv pct", 32'h01, 32'(pct_readout));
        chk_val("adv lamps", 32'h10, 32'(lamps));
        chk_bit("adv no run", 1'b0, meas_run);
        chk_bit("adv source", 1'b0, stse);
        btn[4] = 1'b1;
        cyc(100);
        chk_bit("sensor source", 1'b1, stse);
        btn[4] = 1'b0;
        cyc(100);
        chk_bit("source off", 1'b0, stse);
        btn[1] = 1'b1;
        cyc(100);
        chk_val("held 1", 32'h02, 32'(chan_digits));
        cyc(8900);
        chk_val("held 2", 32'h03, 32'(chan_digits));
        cyc(2000);
        chk_val("held 3", 32'h04, 32'(chan_digits));
        btn[1] = 1'b0;
        cyc(300);
        chk_val("held stop", 32'h04, 32'(chan_digits));
        $display("advance test done");
        last_chan = 5'h1E;
        bad_chan = 5'h03;
        bad_grade = 2'h1;
        press(0);
        wait_stop();
        bad_grade = 2'h2;
        press(3);
        chk_bit("monitor from halt", 1'b1, meas_run);
        chk_val("mon lamps", 32'h04, 32'(lamps));
        chk_val("mon addr", 32'h03, 32'(mux_addr));
        lat = 12'h5DC;
        cyc(50);
        k = 0;
        while (digits_lit !== 1'b0 && k < 1200)
        begin
            cyc(1);
            k++;
        end
        chk_bit("blink", 1'b0, digits_lit);
        btn[2] = 1'b1;
        cyc(100);
        chk_bit("hold stops", 1'b0, meas_run);
        btn[2] = 1'b0;
        cyc(100);
        chk_bit("lit steady", 1'b1, digits_lit);
        lat = 12'h028;
        btn[0] = 1'b1;
        cyc(100);
        chk_bit("run after hold", 1'b1, meas_run);
        chk_val("remeasure addr", 32'h03, 32'(mux_addr));
        btn[0] = 1'b0;
        wait_stop();
        chk_val("halt again", 32'h04, 32'(lamps));
        $display("monitor test done");
        tally_and_finish();
    end
endmodule
